// >>> cict_pkg.sv
// Constants and types for the instruction cycle timing sequencer
package cict_pkg;

	// Instruction lengths in program bytes
	localparam logic [1:0] CICT_LEN_ONE = 2'h1;
	localparam logic [1:0] CICT_LEN_TWO = 2'h2;
	localparam logic [1:0] CICT_LEN_THREE = 2'h3;

	// Execution times in system clock cycles
	localparam logic [3:0] CICT_CYC_ONE = 4'h1;
	localparam logic [3:0] CICT_CYC_TWO = 4'h2;
	localparam logic [3:0] CICT_CYC_THREE = 4'h3;
	localparam logic [3:0] CICT_CYC_FOUR = 4'h4;
	localparam logic [3:0] CICT_CYC_FIVE = 4'h5;
	localparam logic [3:0] CICT_CYC_MUL = 4'h4;
	localparam logic [3:0] CICT_CYC_DIV = 4'h8;

	// Opcodes that need special handling
	localparam logic [7:0] CICT_OP_NOP = 8'h00;
	localparam logic [7:0] CICT_OP_SPARE = 8'ha5;
	localparam logic [7:0] CICT_OP_MUL = 8'ha4;
	localparam logic [7:0] CICT_OP_DIV = 8'h84;

	// Reset values of the sequencer outputs
	localparam logic [3:0] CICT_RST_CYC = 4'h0;
	localparam logic [1:0] CICT_RST_LEN = 2'h0;
	localparam logic [7:0] CICT_RST_OP = 8'h00;

	typedef enum logic [1:0] {
		CICT_IDLE = 2'b01,
		CICT_EXEC = 2'b10
	} cict_state_t;

	// Decoded timing: length, cycles when not taken, conditional flag
	typedef struct packed {
		logic [1:0] len;
		logic [3:0] cyc;
		logic cond;
	} cict_dec_t;

endpackage

// >>> cict_timing.sv
// Instruction length and cycle-count sequencer for the pipelined core
//
// What this block does
// - Timing counts single system clocks only
// - Most instructions: cycles equal byte length
// - Untaken conditional branch is one cycle shorter
// - Bank register arithmetic: 1 byte, 1 cycle
// - Direct/immediate arithmetic: 2 bytes, 2 cycles
// - Indirect arithmetic, INC, DEC: 1 byte, 2 cycles
// - AND/OR/XOR bank register: 1 byte, 1 cycle
// - Logical direct,A: 2 bytes, 2 cycles
// - Logical direct,immediate: 3 bytes, 3 cycles
// - Accumulator single-byte ops take 1 cycle
// - Direct to bank register: 2 bytes, 2 cycles
// - Direct to direct move: 3 bytes, 3 cycles
// - Accumulator store through pointer: 1 byte, 2 cycles
// - Load data pointer pair: 3 bytes, 3 cycles
// - Code read via data pointer: 1 byte, 3 cycles
// - Code read via program counter: 1 byte, 3 cycles
// - External move, 8-bit pointer: 1 byte, 3 cycles
// - External move, 16-bit pointer: 1 byte, 3 cycles
// - Push or pop direct: 2 bytes, 2 cycles
// - Exchange bank register: 1 byte, 1 cycle
// - Low nibble exchange: 1 byte, 2 cycles
// - Standard opcode encoding kept, only timing differs
// - Spare opcode behaves exactly like no-operation
`timescale 1ns/100ps
`default_nettype none

module cict_timing
	import cict_pkg::*;
(
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	// Opcode issue from fetch
	input wire logic I_INSTR_VALID,
	input wire logic [7:0] I_OPCODE,
	input wire logic I_COND_TAKEN,
	output logic O_INSTR_READY,
	// Execution progress
	output logic O_BUSY,
	output logic O_RETIRE,
	output logic [3:0] O_CYCLE_INDEX,
	// Timing of the instruction in flight
	output logic [1:0] O_INSTR_BYTES,
	output logic [3:0] O_INSTR_CYCLES,
	output logic [7:0] O_OPCODE,
	output logic O_NOP_EQUIV
);

	function automatic cict_dec_t cict_mk(input logic [1:0] len, input logic [3:0] cyc,
		input logic cond);
		cict_dec_t r;
		r.len = len;
		r.cyc = cyc;
		r.cond = cond;
		return r;
	endfunction

	// Full opcode map; cycles given for the untaken case of conditionals
	function automatic cict_dec_t cict_decode(input logic [7:0] op);
		cict_dec_t r;
		logic [3:0] hi;
		hi = op[7:4];
		r = cict_mk(CICT_LEN_ONE, CICT_CYC_ONE, 1'b0);
		if (op[3]) begin
			// Bank register operand column
			unique case (hi)
				4'h7, 4'h8, 4'ha: r = cict_mk(CICT_LEN_TWO, CICT_CYC_TWO, 1'b0);
				4'hb: r = cict_mk(CICT_LEN_THREE, CICT_CYC_THREE, 1'b1);
				4'hd: r = cict_mk(CICT_LEN_TWO, CICT_CYC_TWO, 1'b1);
				default: r = cict_mk(CICT_LEN_ONE, CICT_CYC_ONE, 1'b0);
			endcase
		end else if (op[3:1] == 3'h3) begin
			// Indirect pointer register column
			unique case (hi)
				4'h7, 4'h8, 4'ha: r = cict_mk(CICT_LEN_TWO, CICT_CYC_TWO, 1'b0);
				4'hb: r = cict_mk(CICT_LEN_THREE, CICT_CYC_FOUR, 1'b1);
				default: r = cict_mk(CICT_LEN_ONE, CICT_CYC_TWO, 1'b0);
			endcase
		end else begin
			unique case (op[3:0])
				4'h0: begin
					unique case (hi)
						4'h0: r = cict_mk(CICT_LEN_ONE, CICT_CYC_ONE, 1'b0);
						4'h1, 4'h2, 4'h3: r = cict_mk(CICT_LEN_THREE, CICT_CYC_THREE, 1'b1);
						4'h4, 4'h5, 4'h6, 4'h7: r = cict_mk(CICT_LEN_TWO, CICT_CYC_TWO, 1'b1);
						4'h8: r = cict_mk(CICT_LEN_TWO, CICT_CYC_THREE, 1'b0);
						4'h9: r = cict_mk(CICT_LEN_THREE, CICT_CYC_THREE, 1'b0);
						4'he, 4'hf: r = cict_mk(CICT_LEN_ONE, CICT_CYC_THREE, 1'b0);
						default: r = cict_mk(CICT_LEN_TWO, CICT_CYC_TWO, 1'b0);
					endcase
				end
				4'h1: r = cict_mk(CICT_LEN_TWO, CICT_CYC_THREE, 1'b0);
				4'h2: begin
					unique case (hi)
						4'h0, 4'h1: r = cict_mk(CICT_LEN_THREE, CICT_CYC_FOUR, 1'b0);
						4'h2, 4'h3: r = cict_mk(CICT_LEN_ONE, CICT_CYC_FIVE, 1'b0);
						4'he, 4'hf: r = cict_mk(CICT_LEN_ONE, CICT_CYC_THREE, 1'b0);
						default: r = cict_mk(CICT_LEN_TWO, CICT_CYC_TWO, 1'b0);
					endcase
				end
				4'h3: begin
					unique case (hi)
						4'h4, 4'h5, 4'h6: r = cict_mk(CICT_LEN_THREE, CICT_CYC_THREE, 1'b0);
						4'h7, 4'h8, 4'h9: r = cict_mk(CICT_LEN_ONE, CICT_CYC_THREE, 1'b0);
						4'he, 4'hf: r = cict_mk(CICT_LEN_ONE, CICT_CYC_THREE, 1'b0);
						default: r = cict_mk(CICT_LEN_ONE, CICT_CYC_ONE, 1'b0);
					endcase
				end
				4'h4: begin
					unique case (hi)
						4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9:
							r = cict_mk(CICT_LEN_TWO, CICT_CYC_TWO, 1'b0);
						4'h8: r = cict_mk(CICT_LEN_ONE, CICT_CYC_DIV, 1'b0);
						4'ha: r = cict_mk(CICT_LEN_ONE, CICT_CYC_MUL, 1'b0);
						4'hb: r = cict_mk(CICT_LEN_THREE, CICT_CYC_THREE, 1'b1);
						default: r = cict_mk(CICT_LEN_ONE, CICT_CYC_ONE, 1'b0);
					endcase
				end
				default: begin
					unique case (hi)
						4'h7, 4'h8: r = cict_mk(CICT_LEN_THREE, CICT_CYC_THREE, 1'b0);
						4'ha: r = cict_mk(CICT_LEN_ONE, CICT_CYC_ONE, 1'b0);
						4'hb: r = cict_mk(CICT_LEN_THREE, CICT_CYC_FOUR, 1'b1);
						4'hd: r = cict_mk(CICT_LEN_THREE, CICT_CYC_THREE, 1'b1);
						default: r = cict_mk(CICT_LEN_TWO, CICT_CYC_TWO, 1'b0);
					endcase
				end
			endcase
		end
		return r;
	endfunction

	function automatic logic cict_is_nop(input logic [7:0] op);
		return (op == CICT_OP_NOP) || (op == CICT_OP_SPARE);
	endfunction

	cict_state_t state_q;
	cict_dec_t dec;
	logic accept;
	logic retire;
	logic [3:0] idx_q;
	logic [3:0] cyc_q;
	logic [3:0] cyc_d;
	logic [1:0] len_q;
	logic [7:0] op_q;
	logic nop_q;

	assign dec = cict_decode(I_OPCODE);
	// A taken conditional runs one cycle longer than the untaken one
	assign cyc_d = dec.cyc + {3'h0, dec.cond & I_COND_TAKEN};
	// Retire in the last counted cycle; the next opcode is taken in that same cycle
	assign retire = (state_q == CICT_EXEC) && (idx_q == cyc_q);
	assign O_INSTR_READY = (state_q == CICT_IDLE) || retire;
	assign accept = I_INSTR_VALID && O_INSTR_READY;

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			state_q <= CICT_IDLE;
		end else if (accept) begin
			state_q <= CICT_EXEC;
		end else if (retire) begin
			state_q <= CICT_IDLE;
		end
	end

	// One count per system clock, no machine-cycle prescaler
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			idx_q <= CICT_RST_CYC;
		end else if (accept) begin
			idx_q <= CICT_CYC_ONE;
		end else if (retire) begin
			idx_q <= CICT_RST_CYC;
		end else if (state_q == CICT_EXEC) begin
			idx_q <= idx_q + CICT_CYC_ONE;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			cyc_q <= CICT_RST_CYC;
			len_q <= CICT_RST_LEN;
			op_q <= CICT_RST_OP;
			nop_q <= 1'b0;
		end else if (accept) begin
			cyc_q <= cyc_d;
			len_q <= dec.len;
			op_q <= I_OPCODE;
			nop_q <= cict_is_nop(I_OPCODE);
		end
	end

	assign O_BUSY = (state_q == CICT_EXEC);
	assign O_RETIRE = retire;
	assign O_CYCLE_INDEX = idx_q;
	assign O_INSTR_BYTES = len_q;
	assign O_INSTR_CYCLES = cyc_q;
	assign O_OPCODE = op_q;
	assign O_NOP_EQUIV = nop_q;

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_SYS_RST);

	sequence s_one;
		O_RETIRE;
	endsequence
	sequence s_two;
		!O_RETIRE ##1 O_RETIRE;
	endsequence
	sequence s_three;
		!O_RETIRE[*2] ##1 O_RETIRE;
	endsequence
	// Four and five cycle runs, for the longer conditional forms
	sequence s_four;
		!O_RETIRE[*3] ##1 O_RETIRE;
	endsequence
	sequence s_five;
		!O_RETIRE[*4] ##1 O_RETIRE;
	endsequence

	bank_arith_a: assert property ((accept && I_OPCODE[3] && (I_OPCODE[7:4] inside {4'h2, 4'h3,
		4'h9})) |=> s_one and (O_INSTR_BYTES == 2'h1)) else $error("bank arith timing");
	bank_logic_a: assert property ((accept && I_OPCODE[3] && (I_OPCODE[7:4] inside {4'h4, 4'h5,
		4'h6, 4'hc})) |=> s_one) else $error("bank logic timing");
	dir_arith_a: assert property ((accept && (I_OPCODE[3:0] inside {4'h4, 4'h5}) &&
		(I_OPCODE[7:4] inside {4'h2, 4'h3, 4'h9})) |=> (O_INSTR_BYTES == 2'h2) ##0 s_two)
		else $error("direct arith timing");
	ind_arith_a: assert property ((accept && (I_OPCODE[3:1] == 3'h3) &&
		(I_OPCODE[7:4] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'hd, 4'hf}))
		|=> (O_INSTR_BYTES == 2'h1) ##0 s_two) else $error("indirect timing");
	dir_imm_a: assert property ((accept && (I_OPCODE[3:0] == 4'h3) &&
		(I_OPCODE[7:4] inside {4'h4, 4'h5, 4'h6})) |=> (O_INSTR_BYTES == 2'h3) ##0 s_three)
		else $error("logic direct imm timing");
	ext_move_a: assert property ((accept && (I_OPCODE[7:5] == 3'h7) &&
		(I_OPCODE[3:0] inside {4'h0, 4'h2, 4'h3})) |=> s_three)
		else $error("external move timing");
	div_len_a: assert property ((accept && (I_OPCODE == CICT_OP_DIV)) |=>
		!O_RETIRE[*7] ##1 O_RETIRE) else $error("divide timing");
	mul_len_a: assert property ((accept && (I_OPCODE == CICT_OP_MUL)) |=>
		!O_RETIRE[*3] ##1 O_RETIRE) else $error("multiply timing");
	cond_extra_a: assert property ((accept && dec.cond) |=>
		(O_INSTR_CYCLES == $past(dec.cyc) + {3'h0, $past(I_COND_TAKEN)}))
		else $error("conditional branch length");
	spare_nop_a: assert property ((accept && (I_OPCODE == CICT_OP_SPARE)) |=>
		s_one and O_NOP_EQUIV and (O_INSTR_BYTES == 2'h1)) else $error("spare opcode");
	no_wait_a: assert property ((O_RETIRE && I_INSTR_VALID) |=>
		(O_BUSY && (O_CYCLE_INDEX == 4'h1))) else $error("gap between instructions");
	clk_count_a: assert property ((O_BUSY && !O_RETIRE) |=>
		(O_CYCLE_INDEX == $past(O_CYCLE_INDEX) + 4'h1)) else $error("cycle count step");

	// Per-group timing of single opcodes
	acc_ops_a: assert property (
		(accept && (I_OPCODE inside {8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4}))
		|=> s_one and (O_INSTR_BYTES == CICT_LEN_ONE)) else $error("accumulator op timing");
	dir_bank_a: assert property (
		(accept && (I_OPCODE[7:3] == 5'h15)) |=> (O_INSTR_BYTES == CICT_LEN_TWO) ##0 s_two)
		else $error("direct to bank timing");
	dir_dir_a: assert property (
		(accept && (I_OPCODE == 8'h85)) |=> (O_INSTR_BYTES == CICT_LEN_THREE) ##0 s_three)
		else $error("direct to direct timing");
	ptr_store_a: assert property (
		(accept && (I_OPCODE[7:1] == 7'h7b)) |=> (O_INSTR_BYTES == CICT_LEN_ONE) ##0 s_two)
		else $error("pointer store timing");
	ptr_load_a: assert property (
		(accept && (I_OPCODE == 8'h90)) |=> (O_INSTR_BYTES == CICT_LEN_THREE) ##0 s_three)
		else $error("pointer pair load timing");
	code_read_a: assert property (
		(accept && (I_OPCODE inside {8'h83, 8'h93})) |=> (O_INSTR_BYTES == CICT_LEN_ONE) ##0
		s_three) else $error("code byte read timing");
	ext_ptr8_a: assert property (
		(accept && (I_OPCODE[7:5] == 3'h7) && (I_OPCODE[3:1] == 3'h1)) |=>
		(O_INSTR_BYTES == CICT_LEN_ONE) ##0 s_three) else $error("short external move");
	stack_move_a: assert property (
		(accept && (I_OPCODE inside {8'hc0, 8'hd0})) |=> (O_INSTR_BYTES == CICT_LEN_TWO) ##0
		s_two) else $error("stack move timing");
	bank_xchg_a: assert property (
		(accept && (I_OPCODE[7:3] == 5'h19)) |=> s_one and (O_INSTR_BYTES == CICT_LEN_ONE))
		else $error("bank exchange timing");
	nibble_xchg_a: assert property (
		(accept && (I_OPCODE[7:1] == 7'h6b)) |=> (O_INSTR_BYTES == CICT_LEN_ONE) ##0 s_two)
		else $error("low nibble exchange timing");
	logic_dir_a: assert property (
		(accept && (I_OPCODE[3:0] == 4'h2) && (I_OPCODE[7:4] inside {4'h4, 4'h5, 4'h6})) |=>
		(O_INSTR_BYTES == CICT_LEN_TWO) ##0 s_two) else $error("logic direct timing");
	two_byte_a: assert property (
		(accept && (I_OPCODE == 8'he5)) |=> (O_INSTR_BYTES == CICT_LEN_TWO) ##0 s_two)
		else $error("bytes equal cycles");
	nop_plain_a: assert property (
		(accept && (I_OPCODE == CICT_OP_NOP)) |=> s_one and O_NOP_EQUIV)
		else $error("no-operation timing");

	// Conditional forms: taken runs one cycle longer
	jump_taken_a: assert property (
		(accept && (I_OPCODE == 8'h60) && I_COND_TAKEN) |=> (O_INSTR_BYTES == CICT_LEN_TWO)
		##0 s_three) else $error("taken jump timing");
	jump_skip_a: assert property (
		(accept && (I_OPCODE == 8'h60) && !I_COND_TAKEN) |=> s_two)
		else $error("untaken jump timing");
	cmp_taken_a: assert property (
		(accept && (I_OPCODE == 8'hb5) && I_COND_TAKEN) |=> s_five)
		else $error("taken compare timing");
	cmp_imm_a: assert property (
		(accept && (I_OPCODE == 8'hb4) && I_COND_TAKEN) |=> s_four)
		else $error("immediate compare timing");
	cmp_ind_a: assert property (
		(accept && (I_OPCODE[7:1] == 7'h5b) && !I_COND_TAKEN) |=> s_four)
		else $error("indirect compare timing");
	dec_jump_a: assert property (
		(accept && (I_OPCODE == 8'hd5) && !I_COND_TAKEN) |=> (O_INSTR_BYTES == CICT_LEN_THREE)
		##0 s_three) else $error("decrement jump timing");

	// Counter and hand-off housekeeping
	idle_index_a: assert property (
		!O_BUSY |-> (O_CYCLE_INDEX == CICT_RST_CYC))
		else $error("index not cleared when idle");
	first_index_a: assert property (
		accept |=> (O_BUSY && (O_CYCLE_INDEX == CICT_CYC_ONE)))
		else $error("first execution cycle");
	retire_end_a: assert property (
		O_RETIRE |-> (O_BUSY && (O_CYCLE_INDEX == O_INSTR_CYCLES)))
		else $error("retire off the last cycle");
	idle_ready_a: assert property (
		!O_BUSY |-> O_INSTR_READY)
		else $error("idle but not ready");
	op_capture_a: assert property (
		accept |=> ((O_OPCODE == $past(I_OPCODE)) && (O_INSTR_BYTES == $past(dec.len))))
		else $error("opcode capture");
	op_hold_a: assert property (
		(O_BUSY && !O_RETIRE) |=> ($stable(O_OPCODE) && $stable(O_INSTR_CYCLES)))
		else $error("instruction changed in flight");
	index_cap_a: assert property (
		O_BUSY |-> (O_CYCLE_INDEX <= CICT_CYC_DIV))
		else $error("cycle index past eight");

endmodule

`default_nettype wire

// >>> cict_fetch_model.sv
// Fetch source model that offers queued opcodes to the sequencer
`timescale 1ns/100ps
`default_nettype none
module cict_fetch_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Opcode handshake
	input wire logic i_ready,
	output logic o_valid,
	output logic [7:0] o_opcode,
	output logic o_taken
);
	logic [8:0] q_q [$];
	logic acc;
	logic rst_seen;
	initial begin
		o_valid = 1'b0;
		o_opcode = 8'h00;
		o_taken = 1'b0;
	end
	task automatic push(input logic [7:0] op, input logic tk);
		q_q.push_back({op, tk});
	endtask
	// Offer is held until taken; an idle bus shows a changing pattern
	always @(posedge i_clk) begin
		acc = o_valid && i_ready && !i_rst;
		rst_seen = i_rst;
		#1;
		if (acc) begin
			void'(q_q.pop_front());
		end
		if (q_q.size() > 0 && !rst_seen) begin
			o_valid = 1'b1;
			{o_opcode, o_taken} = q_q[0];
		end else begin
			o_valid = 1'b0;
			o_opcode = ~o_opcode;
			o_taken = ~o_taken;
		end
	end
endmodule
`default_nettype wire

// >>> tb_cict_timing.sv
// Self-checking bench for the instruction cycle timing sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_cict_timing
	import cict_pkg::*;
;
	logic clk;
	logic rst;
	logic valid;
	logic taken;
	logic ready;
	logic busy;
	logic retire;
	logic nop_eq;
	logic [7:0] opcode;
	logic [7:0] op_q;
	logic [3:0] idx;
	logic [3:0] cyc;
	logic [1:0] len;
	int error_cnt = 0;
	int checks_done = 0;
	// Opcode, {taken, 0, bytes}, total cycles
	logic [15:0] tbl [42] = '{16'h2811, 16'h3911, 16'h9a11, 16'h2522, 16'h2422, 16'h2612,
		16'h0712, 16'h1612, 16'h5b11, 16'h4811, 16'h6811, 16'h5222, 16'h4333, 16'he411,
		16'hf411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hc411, 16'ha822, 16'h8533,
		16'hf612, 16'h9033, 16'h9313, 16'h8313, 16'he213, 16'hf313, 16'he013, 16'hf013,
		16'hc022, 16'hd022, 16'hc811, 16'hd612, 16'ha414, 16'h8418, 16'h0011, 16'ha511,
		16'h6022, 16'h60a3, 16'hb534, 16'hb5b5};
	cict_fetch_model u_src (.i_clk(clk), .i_rst(rst), .i_ready(ready), .o_valid(valid),
		.o_opcode(opcode), .o_taken(taken));
	cict_timing u_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_INSTR_VALID(valid), .I_OPCODE(opcode),
		.I_COND_TAKEN(taken), .O_INSTR_READY(ready), .O_BUSY(busy), .O_RETIRE(retire),
		.O_CYCLE_INDEX(idx), .O_INSTR_BYTES(len), .O_INSTR_CYCLES(cyc), .O_OPCODE(op_q),
		.O_NOP_EQUIV(nop_eq));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask
	task automatic final_report();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic t_reset();
		repeat (10) @(posedge clk);
		@(negedge clk);
		chk({busy, retire, ready, nop_eq, idx}, {4'b0010, CICT_RST_CYC}, "reset flags");
		chk({len, cyc, 2'h0}, {CICT_RST_LEN, CICT_RST_CYC, 2'h0}, "reset timing");
		chk(op_q, CICT_RST_OP, "reset opcode");
		@(posedge clk);
		#1 rst = 1'b0;
	endtask
	// Whole table issued back to back; each retire cycle is the next accept
	task automatic t_table();
		logic [15:0] e;
		int c;
		int w;
		foreach (tbl[i]) u_src.push(tbl[i][15:8], tbl[i][7]);
		w = 0;
		@(negedge clk);
		while (!(valid && ready) && w < 20) begin
			@(negedge clk);
			w++;
		end
		foreach (tbl[i]) begin
			e = tbl[i];
			c = 0;
			do begin
				@(negedge clk);
				c++;
				chk(8'(idx), 8'(c), "index");
				chk({7'h00, busy}, 8'h01, "busy");
				chk(8'(ready), 8'(retire), "ready");
			end while (retire !== 1'b1 && c < 12);
			chk(8'(c), 8'(e[3:0]), "cycles run");
			chk(8'(len), 8'(e[5:4]), "bytes");
			chk(8'(cyc), 8'(e[3:0]), "cycles shown");
			chk(op_q, e[15:8], "opcode");
			chk(8'(nop_eq), 8'(e[15:8] == 8'h00 || e[15:8] == 8'ha5), "spare");
			if (i < 41) chk(8'(valid && ready), 8'h01, "gap");
		end
		@(negedge clk);
		chk(8'({busy, idx}), 8'h00, "idle");
	endtask
	// Reset in mid divide abandons the long operation at once
	task automatic t_mid_reset();
		int w;
		u_src.push(CICT_OP_DIV, 1'b0);
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk({4'h0, busy, 3'h0}, 8'h08, "divide running");
		chk(8'(cyc), 8'(CICT_CYC_DIV), "divide cycles");
		@(posedge clk);
		#1 rst = 1'b1;
		@(posedge clk);
		#1 rst = 1'b0;
		@(negedge clk);
		chk(8'({busy, ready, idx}), 8'h10, "after reset");
		u_src.push(CICT_OP_MUL, 1'b0);
		w = 0;
		while (!(valid && ready) && w < 20) begin
			@(negedge clk);
			w++;
		end
		repeat (3) @(negedge clk);
		chk(8'({busy, retire}), 8'h02, "multiply running");
		@(negedge clk);
		chk(8'({busy, retire}), 8'h03, "multiply retired");
	endtask
	initial begin
		rst = 1'b1;
		t_reset();
		t_table();
		t_mid_reset();
		final_report();
	end
	initial begin
		#200000;
		error_cnt++;
		final_report();
	end
endmodule
`default_nettype wire
